// [src/port_status_low.v]
// Root hub port status: attach, enable and suspend bits
`include "port_status_regs.vh"
module port_status_low (
    // Clock and reset
    input  wire        clk_i,
    input  wire        sys_rst_i,
    // Register access
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [31:0] reg_wdata_i,
    output reg  [2:0]  reg_rdata_o,
    // Downstream port line state (asynchronous)
    input  wire        line_attached_i,
    input  wire        line_resume_i,
    // Events from neighbouring logic (same clock)
    input  wire        non_removable_i,
    input  wire        overcurrent_i,
    input  wire        power_off_i,
    input  wire        bus_error_i,
    input  wire        port_reset_done_changed_i,
    input  wire        port_suspend_changed_i,
    input  wire        bus_resume_state_i,
    // Flags toward neighbouring logic
    output reg         attach_changed_set_o,
    output reg         enable_changed_set_o,
    output reg         resume_to_host_o
);

////////////////////////////////////////////////////////////////////////
// Line level synchronisers
reg        attach_meta_r;
reg        attach_sync_r;
reg        resume_meta_r;
reg        resume_sync_r;

// Port state and next values
reg        attach_prev_r;
reg        port_enabled_r;
reg        port_suspended_r;
reg        port_enabled_nxt;
reg        port_suspended_nxt;
reg        enable_lost;
reg        attach_changed_nxt;
reg        resume_to_host_nxt;
reg  [2:0] rdata_nxt;

// Decoded commands and events
wire       device_attached;
wire       hit;
wire       wr_clr_en;
wire       wr_set_en;
wire       wr_set_susp;
wire       detach_evt;
wire       fault_evt;
wire       enable_done;

////////////////////////////////////////////////////////////////////////
// One command bit of a register write
function cmd_bit;
    input         hit_f;
    input  [31:0] wdata_f;
    input integer pos_f;
    begin
        cmd_bit = hit_f & wdata_f[pos_f];
    end
endfunction

// A set command only takes effect on an attached port
function set_allowed;
    input cmd_f;
    input att_f;
    begin
        set_allowed = cmd_f & att_f;
    end
endfunction

// Any cause on the root hub side that takes the enable away
function fault_any;
    input oc_f;
    input pwr_f;
    input err_f;
    input det_f;
    begin
        fault_any = oc_f | pwr_f | err_f | det_f;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Non-removable port reads attached whatever the line says
assign device_attached = attach_sync_r | non_removable_i;
assign hit             = reg_wr_i & (reg_addr_i == `ROOT_HUB_PORT_STATUS_OFS);
assign wr_clr_en       = cmd_bit(hit, reg_wdata_i, `FLD_DEVICE_ATTACHED);
assign wr_set_en       = cmd_bit(hit, reg_wdata_i, `FLD_PORT_ENABLED);
assign wr_set_susp     = cmd_bit(hit, reg_wdata_i, `FLD_PORT_SUSPENDED);
// Fall of attach, so dropping the non-removable flag counts too
assign detach_evt      = attach_prev_r & ~device_attached;
assign fault_evt       = fault_any(overcurrent_i, power_off_i, bus_error_i, detach_evt);
// Resume and reset timers live elsewhere; only their flags arrive
assign enable_done     = port_reset_done_changed_i | port_suspend_changed_i;

////////////////////////////////////////////////////////////////////////
// Two stages because the attach level is asynchronous
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        attach_meta_r <= `RST_ATTACH_LEVEL;
        attach_sync_r <= `RST_ATTACH_LEVEL;
    end else begin
        attach_meta_r <= line_attached_i;
        attach_sync_r <= attach_meta_r;
    end
end

// Same for the resume level
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        resume_meta_r <= 1'b0;
        resume_sync_r <= 1'b0;
    end else begin
        resume_meta_r <= line_resume_i;
        resume_sync_r <= resume_meta_r;
    end
end

////////////////////////////////////////////////////////////////////////
// Enable: write set, completion set, clear write, faults, attach
always @* begin
    port_enabled_nxt = port_enabled_r;
    enable_lost      = 1'b0;
    if (set_allowed(wr_set_en, device_attached)) begin
        port_enabled_nxt = 1'b1;
    end
    if (enable_done) begin
        port_enabled_nxt = 1'b1;
    end
    if (wr_clr_en) begin
        port_enabled_nxt = 1'b0;
    end
    // Faults win over every set source
    if (fault_evt) begin
        port_enabled_nxt = 1'b0;
        enable_lost      = port_enabled_r;
    end
    // Never enabled without a device
    if (!device_attached) begin
        port_enabled_nxt = 1'b0;
        enable_lost      = port_enabled_r;
    end
end

////////////////////////////////////////////////////////////////////////
// Suspend: a clear in the same cycle beats a write set
always @* begin
    port_suspended_nxt = port_suspended_r;
    if (set_allowed(wr_set_susp, device_attached)) begin
        port_suspended_nxt = 1'b1;
    end
    if (port_suspend_changed_i) begin
        port_suspended_nxt = 1'b0;
    end
    if (port_reset_done_changed_i || bus_resume_state_i) begin
        port_suspended_nxt = 1'b0;
    end
    if (!device_attached) begin
        port_suspended_nxt = 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// Flag and read-back values, registered below
always @* begin
    attach_changed_nxt = 1'b0;
    resume_to_host_nxt = resume_sync_r & port_suspended_r;
    rdata_nxt          = {port_suspended_nxt, port_enabled_nxt, device_attached};
    // Set commands on an empty port go to the attach-change flag
    if (!device_attached && (wr_set_en || wr_set_susp)) begin
        attach_changed_nxt = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// Port state
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        attach_prev_r    <= 1'b0;
        port_enabled_r   <= `RST_PORT_ENABLED;
        port_suspended_r <= `RST_PORT_SUSPENDED;
    end else begin
        attach_prev_r    <= device_attached;
        port_enabled_r   <= port_enabled_nxt;
        port_suspended_r <= port_suspended_nxt;
    end
end

// Outputs from flops; read-back shows the state after this edge
always @(posedge clk_i) begin
    if (sys_rst_i) begin
        reg_rdata_o          <= 3'h0;
        attach_changed_set_o <= 1'b0;
        enable_changed_set_o <= 1'b0;
        resume_to_host_o     <= 1'b0;
    end else begin
        reg_rdata_o          <= rdata_nxt;
        attach_changed_set_o <= attach_changed_nxt;
        enable_changed_set_o <= enable_lost;
        resume_to_host_o     <= resume_to_host_nxt;
    end
end

endmodule

// [src/port_status_regs.vh]
// Offsets, field positions and reset values of the port status low bits
`ifndef PORT_STATUS_REGS_VH
`define PORT_STATUS_REGS_VH
`define ROOT_HUB_PORT_STATUS_OFS  8'h54
`define FLD_DEVICE_ATTACHED       0
`define FLD_PORT_ENABLED          1
`define FLD_PORT_SUSPENDED        2
`define RST_PORT_ENABLED          1'b0
`define RST_PORT_SUSPENDED        1'b0
`define RST_ATTACH_LEVEL          1'b0
`endif

// [testbench/port_line_model.sv]
// Downstream port model: attach and resume line levels
module port_line_model (
    input  wire logic clk_i,
    input  wire logic plug_i,
    input  wire logic wake_i,
    output logic      attached_o = 1'b0,
    output logic      resume_o = 1'b0
);
timeunit 1ns;
timeprecision 1ns;
// Lines move off the edge; a detached port cannot signal resume
always @(posedge clk_i) begin
    attached_o <= #7 plug_i;
    resume_o <= #7 wake_i && plug_i;
end
endmodule

// [testbench/port_status_low_properties.sv]
// Checker for the port status low bits
module port_status_low_properties (
    input wire logic        clk_i, sys_rst_i, reg_wr_i, line_resume_i, non_removable_i,
    input wire logic        overcurrent_i, power_off_i, bus_error_i, bus_resume_state_i,
    input wire logic        port_reset_done_changed_i, port_suspend_changed_i,
    input wire logic        attach_changed_set_o, enable_changed_set_o, resume_to_host_o,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [2:0]  reg_rdata_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (sys_rst_i);
wire wr = reg_wr_i && reg_addr_i == 8'h54;
wire flt = overcurrent_i || power_off_i || bus_error_i;
wire [2:0] r = reg_rdata_o;
a_empty_redirect: assert property (
    wr && |reg_wdata_i[2:1] && !r[0] |=> attach_changed_set_o) else $error("no redirect");
a_no_enable_empty: assert property (
    !r[0] [*2] |-> !r[1]) else $error("enabled while empty");
a_write_clears: assert property (
    wr && reg_wdata_i[0] |=> !r[1]) else $error("enable kept");
a_fault_clears: assert property (
    flt |=> !r[1]) else $error("fault kept enable");
a_fault_flags: assert property (
    flt && r[1] |=> enable_changed_set_o) else $error("no enable change");
a_suspend_ends: assert property (
    port_suspend_changed_i || port_reset_done_changed_i || bus_resume_state_i |=> !r[2])
    else $error("suspend kept");
a_fixed_attach: assert property (
    non_removable_i [*2] |=> r[0]) else $error("fixed port detached");
a_resume_fwd: assert property (
    (line_resume_i && r[2]) [*4] |=> resume_to_host_o) else $error("resume lost");
endmodule
bind port_status_low port_status_low_properties i_props (.*);

// [testbench/tb.sv]
// Table driven test of the port status low bits
module tb;
timeunit 1ns;
timeprecision 1ns;
typedef struct packed {logic [2:0] lv; logic [7:0] a; logic [2:0] d; logic [5:0] e, x;} step_t;
logic       clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, plug = 0, wake = 0, nonrem = 0;
logic [7:0] adr = 0;
logic [2:0] dat = 0, rd;
logic [5:0] ev = 0;
wire        at, lr, ac, ec, rh;
int         err_count = 0, n_compared = 0;
// Levels {nonrem,wake,plug}, address, data, events, expected {flags,read}
step_t tbl [16] = '{'{3'h0, 8'h54, 3'h6, 6'h00, 6'h20},
    '{3'h1, 8'h50, 3'h2, 6'h00, 6'h01}, '{3'h1, 8'h54, 3'h6, 6'h00, 6'h07},
    '{3'h3, 8'h00, 3'h0, 6'h00, 6'h0f}, '{3'h1, 8'h00, 3'h0, 6'h01, 6'h03},
    '{3'h1, 8'h54, 3'h1, 6'h00, 6'h01}, '{3'h1, 8'h00, 3'h0, 6'h02, 6'h03},
    '{3'h1, 8'h00, 3'h0, 6'h10, 6'h11}, '{3'h1, 8'h54, 3'h2, 6'h00, 6'h03},
    '{3'h1, 8'h00, 3'h0, 6'h08, 6'h11}, '{3'h1, 8'h54, 3'h2, 6'h00, 6'h03},
    '{3'h1, 8'h00, 3'h0, 6'h04, 6'h11}, '{3'h1, 8'h54, 3'h4, 6'h00, 6'h05},
    '{3'h1, 8'h00, 3'h0, 6'h20, 6'h01}, '{3'h4, 8'h54, 3'h2, 6'h00, 6'h03},
    '{3'h0, 8'h00, 3'h0, 6'h00, 6'h00}};
initial forever #20 clk_i = ~clk_i;
port_line_model i_line (.clk_i, .plug_i(plug), .wake_i(wake), .attached_o(at), .resume_o(lr));
port_status_low i_dut (.clk_i, .sys_rst_i, .reg_addr_i(adr), .reg_wr_i,
    .reg_wdata_i({29'h0, dat}), .reg_rdata_o(rd), .line_attached_i(at), .line_resume_i(lr),
    .non_removable_i(nonrem), .overcurrent_i(ev[4]), .power_off_i(ev[3]), .bus_error_i(ev[2]),
    .port_reset_done_changed_i(ev[1]), .port_suspend_changed_i(ev[0]),
    .bus_resume_state_i(ev[5]), .attach_changed_set_o(ac), .enable_changed_set_o(ec),
    .resume_to_host_o(rh));
task final_report;
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task chk(input logic [5:0] x);
    n_compared++;
    if ({ac, ec, rh, rd} !== x) begin
        err_count++;
        $display("unexpected at %0t: got %b want %b", $time, {ac, ec, rh, rd}, x);
    end
endtask
// Five idle cycles per step cover the two-stage line sync and let pulses pass
initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 0;
    foreach (tbl[i]) begin
        @(posedge clk_i);
        {nonrem, wake, plug} <= tbl[i].lv;
        repeat (5) @(posedge clk_i);
        {reg_wr_i, adr, dat, ev} <= {tbl[i].d != 3'h0, tbl[i].a, tbl[i].d, tbl[i].e};
        @(posedge clk_i);
        {reg_wr_i, ev} <= 7'h00;
        #1 chk(tbl[i].x);
    end
    final_report;
end
endmodule
